// File: hw/igc_defines.vh
// Constants for the ion generator control block
`ifndef IGC_DEFINES_VH
`define IGC_DEFINES_VH
`define IGC_CLK_HZ 50000000
`define IGC_TICK_CYCLES (`IGC_CLK_HZ)
`define IGC_TEMP_HI_C 8'h23
`define IGC_TEMP_LO_C 8'h05
`define IGC_TEMP_OK_MIN 6
`define IGC_TEMP_OK_S (`IGC_TEMP_OK_MIN * 60)
`define IGC_FAN_MIN_RPM 12'h168
`define IGC_DISC_DELAY_S 1
`define IGC_DISC_WIN_DS 60
`define IGC_DISC_ABN_DS 59
`define IGC_DISC_OFF_MIN 5
`define IGC_DISC_OFF_S (`IGC_DISC_OFF_MIN * 60)
`define IGC_DISC_LIM_CHK 4'h1
`define IGC_DISC_LIM 4'h3
`define IGC_DIS_ARM_MIN 30
`define IGC_DIS_ARM_S (`IGC_DIS_ARM_MIN * 60)
`define IGC_DIS_ABN_S 5
`define IGC_DIS_OFF_MIN 30
`define IGC_DIS_OFF_S (`IGC_DIS_OFF_MIN * 60)
`define IGC_DIS_LIM 4'hC
`define IGC_DIS_CLR_MIN 50
`define IGC_DIS_CLR_S (`IGC_DIS_CLR_MIN * 60)
`define IGC_FAN_AUTO 3'h0
`define IGC_FAN_COOL_MED 3'h3
`define IGC_ST_OFF 2'h0
`define IGC_ST_IND 2'h1
`define IGC_ST_COMB 2'h2
`define IGC_ADDR_CTRL 4'h0
`define IGC_ADDR_STAT 4'h4
`define IGC_ADDR_CNT 4'h8
`endif

// File: hw/igc_top.v
// Ion generator control: operation state, pause logic and fault detection
//
// Functional notes
// - Ion on while running starts combination
// - Ion on while off starts individual
// - Power off, ion button, off timer stop
// - Pause generation while indoor fan stopped
// - Intake temperature band pause, six minutes
// - Combination: generator needs fan 360 rpm
// - Individual: remote fan, auto is medium
// - Powerful and quiet disabled during ion
// - Vanes: remote in individual, mode otherwise
// - On timer when stopped restores ion
// - On timer while running changes nothing
// - Off timer stops all, saves ion
// - Resume saved operation after power failure
// - Disconnection check: 1s delay, 6s window
// - Disconnection: count, five minutes off, restart
// - Check mode: one count declares fault
// - Normal mode: three counts declare fault
// - Clear disconnection count on stop, except in check mode
// - Discharge armed after 30 minutes, 5s
// - Discharge: count, 30 minutes off, log 12
// - Clear discharge count: 50 minutes, stop
`include "igc_defines.vh"
module igc_top #(
	parameter TICK_CYCLES = `IGC_TICK_CYCLES
) (
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	input wire cmd_power,
	input wire cmd_ion_btn,
	input wire on_timer_fire,
	input wire off_timer_fire,
	input wire check_mode,
	input wire mode_running,
	input wire mode_ctrl_stop,
	input wire fan_running,
	input wire [11:0] fan_rpm,
	input wire [7:0] intake_temp,
	input wire [2:0] remote_fan,
	input wire [2:0] mode_fan,
	input wire [2:0] remote_swing,
	input wire [2:0] mode_swing,
	input wire req_powerful,
	input wire req_quiet,
	input wire [1:0] nv_op_state,
	input wire nv_valid,
	input wire gen_abnormal,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	output reg gen_power,
	output reg [2:0] fan_speed_out,
	output reg [2:0] swing_out,
	output reg powerful_en,
	output reg quiet_en,
	output reg ion_led,
	output reg timer_led_blink,
	output reg nv_fault_wr,
	output reg nv_fault_hidden,
	output reg [1:0] op_state
);
	// ************************************************************
	// Sized timing constants
	// ************************************************************
	// Backoff spans sized to the backoff counter, so loads never drop bits
	localparam [11:0] DISC_OFF_SEC = `IGC_DISC_OFF_S;
	localparam [11:0] DIS_OFF_SEC = `IGC_DIS_OFF_S;
	// Longest span (discharge count clear, 50 minutes) must fit twelve bits of seconds
	localparam [11:0] TEMP_OK_LAST = `IGC_TEMP_OK_S - 1;
	localparam [11:0] DIS_CLR_LAST = `IGC_DIS_CLR_S - 1;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	reg abn_s1_reg;
	reg abn_s2_reg;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			abn_s1_reg <= 1'b0;
			abn_s2_reg <= 1'b0;
		end else if (clk_en) begin
			abn_s1_reg <= gen_abnormal;
			abn_s2_reg <= abn_s1_reg;
		end
	end

	// ************************************************************
	// Time base
	// ************************************************************
	// A tenth-second tick as well, since the abnormal run is 5.9 s
	localparam [25:0] DS_CYC = TICK_CYCLES / 10;
	reg [25:0] ds_cnt_reg;
	reg [3:0] ds_num_reg;
	wire ds_tick = (ds_cnt_reg == DS_CYC - 26'h1);
	wire sec_tick = ds_tick && (ds_num_reg == 4'h9);
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ds_cnt_reg <= 26'h0;
			ds_num_reg <= 4'h0;
		end else if (clk_en) begin
			ds_cnt_reg <= ds_tick ? 26'h0 : ds_cnt_reg + 26'h1;
			if (ds_tick)
				ds_num_reg <= (ds_num_reg == 4'h9) ? 4'h0 : ds_num_reg + 4'h1;
		end
	end

	// ************************************************************
	// Operation state
	// ************************************************************
	reg [1:0] saved_reg;
	reg boot_reg;
	reg [1:0] op_next;
	wire stop_evt = (op_state != `IGC_ST_OFF) && (op_next == `IGC_ST_OFF);
	always @* begin
		op_next = op_state;
		case (op_state)
			`IGC_ST_OFF: begin
				if (on_timer_fire)
					op_next = saved_reg;
				else if (cmd_ion_btn)
					op_next = mode_running ? `IGC_ST_COMB : `IGC_ST_IND;
			end
			`IGC_ST_IND, `IGC_ST_COMB: begin
				if (cmd_power || cmd_ion_btn || off_timer_fire)
					op_next = `IGC_ST_OFF;
				else if (mode_running)
					op_next = `IGC_ST_COMB;
				else
					op_next = `IGC_ST_IND;
			end
			default: op_next = `IGC_ST_OFF;
		endcase
		if (op_state == `IGC_ST_OFF && cmd_ion_btn && mode_running && !on_timer_fire)
			op_next = `IGC_ST_COMB;
	end
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			op_state <= `IGC_ST_OFF;
			saved_reg <= `IGC_ST_OFF;
			boot_reg <= 1'b1;
		end else if (clk_en) begin
			boot_reg <= 1'b0;
			if (boot_reg) begin
				if (nv_valid)
					op_state <= nv_op_state;
			end else begin
				op_state <= op_next;
			end
			if (off_timer_fire && op_state != `IGC_ST_OFF)
				saved_reg <= op_state;
			else if (off_timer_fire && mode_running)
				saved_reg <= `IGC_ST_OFF;
		end
	end
	wire ion_on = (op_state != `IGC_ST_OFF);

	// ************************************************************
	// Pause conditions
	// ************************************************************
	reg [8:0] temp_ok_reg;
	reg temp_pause_reg;
	wire temp_out = (intake_temp >= `IGC_TEMP_HI_C) || (intake_temp <= `IGC_TEMP_LO_C);
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			temp_ok_reg <= 9'h0;
			temp_pause_reg <= 1'b0;
		end else if (clk_en) begin
			if (temp_out) begin
				temp_ok_reg <= 9'h0;
				temp_pause_reg <= 1'b1;
			end else if (temp_pause_reg && sec_tick) begin
				if ({3'h0, temp_ok_reg} == TEMP_OK_LAST) begin
					temp_pause_reg <= 1'b0;
					temp_ok_reg <= 9'h0;
				end else begin
					temp_ok_reg <= temp_ok_reg + 9'h1;
				end
			end
		end
	end
	wire fan_ok = fan_running &&
		((op_state != `IGC_ST_COMB) || (fan_rpm >= `IGC_FAN_MIN_RPM));
	wire gen_want = ion_on && fan_ok && !temp_pause_reg;

	// ************************************************************
	// Fault detection
	// ************************************************************
	reg [11:0] on_sec_reg;
	reg [6:0] win_reg;
	reg [6:0] abn_ds_reg;
	reg [2:0] abn_s_reg;
	reg [11:0] off_reg;
	reg [11:0] norm_reg;
	reg [3:0] disc_cnt_reg;
	reg [3:0] dis_cnt_reg;
	reg disc_fault_reg;
	reg dis_logged_reg;
	wire in_backoff = (off_reg != 12'h0);
	wire gen_live = gen_want && !in_backoff && !disc_fault_reg;
	wire disc_hit = gen_live && on_sec_reg >= `IGC_DISC_DELAY_S && ds_tick &&
		abn_s2_reg && (abn_ds_reg == `IGC_DISC_ABN_DS - 1) &&
		(win_reg < `IGC_DISC_WIN_DS);
	wire dis_hit = gen_live && !disc_hit && on_sec_reg >= `IGC_DIS_ARM_S && sec_tick &&
		abn_s2_reg && (abn_s_reg == `IGC_DIS_ABN_S - 1);
	wire [3:0] disc_lim = check_mode ? `IGC_DISC_LIM_CHK : `IGC_DISC_LIM;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			on_sec_reg <= 12'h0;
			win_reg <= 7'h0;
			abn_ds_reg <= 7'h0;
			abn_s_reg <= 3'h0;
			off_reg <= 12'h0;
			norm_reg <= 12'h0;
			disc_cnt_reg <= 4'h0;
			dis_cnt_reg <= 4'h0;
			disc_fault_reg <= 1'b0;
			dis_logged_reg <= 1'b0;
			nv_fault_wr <= 1'b0;
			nv_fault_hidden <= 1'b0;
		end else if (clk_en) begin
			nv_fault_wr <= 1'b0;
			nv_fault_hidden <= 1'b0;
			if (!gen_live) begin
				on_sec_reg <= 12'h0;
				win_reg <= 7'h0;
				abn_ds_reg <= 7'h0;
				abn_s_reg <= 3'h0;
			end else begin
				if (sec_tick && on_sec_reg != 12'hFFF)
					on_sec_reg <= on_sec_reg + 12'h1;
				if (ds_tick && on_sec_reg >= `IGC_DISC_DELAY_S && win_reg < `IGC_DISC_WIN_DS)
					win_reg <= win_reg + 7'h1;
				if (ds_tick)
					abn_ds_reg <= abn_s2_reg ? abn_ds_reg + 7'h1 : 7'h0;
				if (sec_tick)
					abn_s_reg <= abn_s2_reg ? abn_s_reg + 3'h1 : 3'h0;
			end
			if (in_backoff && sec_tick)
				off_reg <= off_reg - 12'h1;
			if (disc_hit) begin
				disc_cnt_reg <= disc_cnt_reg + 4'h1;
				off_reg <= DISC_OFF_SEC;
				if (disc_cnt_reg + 4'h1 >= disc_lim) begin
					disc_fault_reg <= 1'b1;
					nv_fault_wr <= 1'b1;
				end
			end
			if (dis_hit) begin
				if (dis_cnt_reg != 4'hF)
					dis_cnt_reg <= dis_cnt_reg + 4'h1;
				off_reg <= DIS_OFF_SEC;
				if (dis_cnt_reg + 4'h1 >= `IGC_DIS_LIM && !dis_logged_reg) begin
					dis_logged_reg <= 1'b1;
					nv_fault_hidden <= 1'b1;
				end
			end
			if (gen_live && !abn_s2_reg) begin
				if (sec_tick) begin
					if (norm_reg == DIS_CLR_LAST) begin
						norm_reg <= 12'h0;
						if (!dis_hit)
							dis_cnt_reg <= 4'h0;
					end else begin
						norm_reg <= norm_reg + 12'h1;
					end
				end
			end else begin
				norm_reg <= 12'h0;
			end
			if (stop_evt || mode_ctrl_stop) begin
				dis_cnt_reg <= 4'h0;
				dis_logged_reg <= 1'b0;
				off_reg <= 12'h0;
				if (!check_mode) begin
					disc_cnt_reg <= 4'h0;
					disc_fault_reg <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gen_power <= 1'b0;
			fan_speed_out <= 3'h0;
			swing_out <= 3'h0;
			powerful_en <= 1'b0;
			quiet_en <= 1'b0;
			ion_led <= 1'b0;
			timer_led_blink <= 1'b0;
		end else if (clk_en) begin
			gen_power <= gen_live;
			if (op_state == `IGC_ST_IND)
				fan_speed_out <= (remote_fan == `IGC_FAN_AUTO) ? `IGC_FAN_COOL_MED : remote_fan;
			else
				fan_speed_out <= mode_fan;
			swing_out <= (op_state == `IGC_ST_IND) ? remote_swing : mode_swing;
			powerful_en <= req_powerful && !ion_on;
			quiet_en <= req_quiet && !ion_on;
			ion_led <= ion_on && !disc_fault_reg;
			timer_led_blink <= disc_fault_reg && check_mode;
		end
	end

	// ************************************************************
	// Register port
	// ************************************************************
	// Control register reads zero and ignores writes; state comes from pins
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0;
		end else if (clk_en) begin
			reg_rdata <= 32'h0;
			if (reg_rd) begin
				case (reg_addr)
					`IGC_ADDR_STAT: reg_rdata <= {24'h0, dis_logged_reg, disc_fault_reg,
						temp_pause_reg, gen_live, in_backoff, ion_on, op_state};
					`IGC_ADDR_CNT: reg_rdata <= {24'h0, dis_cnt_reg, disc_cnt_reg};
					default: reg_rdata <= 32'h0;
				endcase
			end
		end
	end
endmodule

// File: bench/igc_top_asserts.sv
// Port-level checks for the ion generator control block
module igc_top_asserts(
	input wire sys_clk,
	input wire nrst,
	input wire cmd_power,
	input wire cmd_ion_btn,
	input wire on_timer_fire,
	input wire off_timer_fire,
	input wire mode_running,
	input wire mode_ctrl_stop,
	input wire fan_running,
	input wire [11:0] fan_rpm,
	input wire [7:0] intake_temp,
	input wire [2:0] remote_fan,
	input wire [2:0] mode_swing,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire gen_power,
	input wire [2:0] fan_speed_out,
	input wire [2:0] swing_out,
	input wire powerful_en,
	input wire quiet_en,
	input wire ion_led,
	input wire nv_fault_wr,
	input wire [1:0] op_state
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_ion_start: assert property (
		cmd_ion_btn && op_state == 2'h0 && !cmd_power && !on_timer_fire && !off_timer_fire
		&& !mode_ctrl_stop |=> op_state == ($past(mode_running) ? 2'h2 : 2'h1))
		else $error("ion request gave wrong state");
	a_off_timer: assert property (off_timer_fire |=> op_state == 2'h0)
		else $error("off timer did not stop");
	a_off_idle: assert property ((op_state == 2'h0)[*2] |-> !gen_power)
		else $error("generator on while off");
	a_fan_pause: assert property ((!fan_running)[*4] |-> !gen_power)
		else $error("generator on with fan stopped");
	a_temp_pause: assert property (
		(intake_temp >= 8'h23 || intake_temp <= 8'h05)[*4] |-> !gen_power)
		else $error("generator on outside temperature band");
	a_rpm_gate: assert property ((op_state == 2'h2 && fan_rpm < 12'h168)[*4] |-> !gen_power)
		else $error("generator on at low fan speed");
	a_ind_fan: assert property (
		(op_state == 2'h1 && remote_fan == 3'h0)[*2] |-> fan_speed_out == 3'h3)
		else $error("auto fan not medium");
	a_opts_off: assert property ((op_state != 2'h0)[*2] |-> !powerful_en && !quiet_en)
		else $error("powerful or quiet enabled");
	a_comb_swing: assert property (
		(op_state == 2'h2 && $stable(mode_swing))[*2] |-> swing_out == mode_swing)
		else $error("swing not following mode");
	a_fault_led: assert property (nv_fault_wr |-> ##[0:2] !ion_led)
		else $error("ion lamp lit after fault");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	c_ind: cover property (op_state == 2'h1);
	c_comb: cover property (op_state == 2'h2);
	c_fault: cover property (nv_fault_wr);
endmodule

// File: bench/igc_remote.sv
// Behavioural remote decoder and mode controller feeding the block
module igc_remote(
	input wire logic sys_clk,
	output logic [3:0] cmd,
	output logic mode_running,
	output logic fan_running,
	output logic [11:0] fan_rpm,
	output logic [7:0] intake_temp,
	output logic [2:0] fan_sel,
	output logic [2:0] swing_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd = 4'h0;
		mode_running = 1'h0;
		fan_running = 1'h1;
		fan_rpm = 12'h190;
		intake_temp = 8'h14;
		fan_sel = 3'h0;
		swing_sel = 3'h5;
	end
	// Pulses last one cycle; the clearing edge keeps back-to-back presses distinct
	task automatic press(input int k);
		@(posedge sys_clk);
		cmd[k] <= 1'h1;
		@(posedge sys_clk);
		cmd <= 4'h0;
	endtask
	task automatic env(input logic run, input logic fan, input logic [11:0] rpm,
		input logic [7:0] t);
		@(posedge sys_clk);
		mode_running <= run;
		fan_running <= fan;
		fan_rpm <= rpm;
		intake_temp <= t;
	endtask
endmodule

// File: bench/igc_top_tb.sv
// Self-checking bench for the ion generator control block
module igc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, nrst = 0, check_mode = 0, nv_valid = 0, gen_abnormal = 0;
	logic reg_wr = 0, reg_rd = 0, opt_req = 1;
	logic [1:0] nv_op_state = 2'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [3:0] cmd;
	logic mode_running, fan_running;
	logic [11:0] fan_rpm;
	logic [7:0] intake_temp;
	logic [2:0] fan_sel, swing_sel, fan_speed_out, swing_out;
	logic [31:0] reg_rdata, d;
	logic [1:0] op_state;
	logic gen_power, powerful_en, quiet_en, ion_led, timer_led_blink, nv_fault_wr;
	int miscompares = 0, compares = 0;
	always #10 sys_clk = ~sys_clk;
	igc_remote i_igc_remote(.sys_clk, .cmd, .mode_running, .fan_running, .fan_rpm,
		.intake_temp, .fan_sel, .swing_sel);
	// Short tick keeps the six-minute band wait inside the run budget
	igc_top #(.TICK_CYCLES(100)) i_igc_top(.sys_clk, .nrst, .clk_en(1'h1), .cmd_power(cmd[0]),
		.cmd_ion_btn(cmd[1]), .on_timer_fire(cmd[2]), .off_timer_fire(cmd[3]), .check_mode,
		.mode_running, .mode_ctrl_stop(1'h0), .fan_running, .fan_rpm, .intake_temp,
		.remote_fan(fan_sel), .mode_fan(~fan_sel), .remote_swing(swing_sel),
		.mode_swing(~swing_sel), .req_powerful(opt_req), .req_quiet(opt_req), .nv_op_state,
		.nv_valid,
		.gen_abnormal, .reg_addr, .reg_wdata(32'hFFFFFFFF), .reg_wr, .reg_rd, .reg_rdata,
		.gen_power, .fan_speed_out, .swing_out, .powerful_en, .quiet_en, .ion_led,
		.timer_led_blink, .nv_fault_wr, .nv_fault_hidden(), .op_state);
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic wr(input logic [3:0] a);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic ion(input int k);
		i_igc_remote.press(k);
		cyc(3);
	endtask
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#(60000 * 20);
		miscompares++;
		complete_run();
	end
	initial begin
		cyc(8);
		chk("reset gen", gen_power, 0);
		nrst <= 1'h1;
		cyc(3);
		chk("idle opts", {powerful_en, quiet_en}, 3);
		ion(1);
		chk("ind state", op_state, 1);
		chk("ind gen", gen_power, 1);
		chk("ind fan", fan_speed_out, 3);
		chk("ind swing", swing_out, 5);
		chk("ind opts", {powerful_en, quiet_en}, 0);
		i_igc_remote.env(0, 0, 12'h190, 8'h14);
		cyc(4);
		chk("fan stop gen", gen_power, 0);
		i_igc_remote.env(0, 1, 12'h190, 8'h14);
		cyc(4);
		chk("fan run gen", gen_power, 1);
		i_igc_remote.env(0, 1, 12'h190, 8'h23);
		cyc(4);
		chk("hot gen", gen_power, 0);
		i_igc_remote.env(0, 1, 12'h190, 8'h05);
		cyc(4);
		chk("cold gen", gen_power, 0);
		i_igc_remote.env(0, 1, 12'h190, 8'h14);
		cyc(35800);
		chk("band early gen", gen_power, 0);
		cyc(400);
		chk("band late gen", gen_power, 1);
		ion(3);
		chk("off timer state", op_state, 0);
		chk("off timer gen", gen_power, 0);
		ion(2);
		chk("on timer restore", op_state, 1);
		ion(2);
		chk("on timer running", op_state, 1);
		ion(1);
		chk("button stop", op_state, 0);
		i_igc_remote.env(1, 1, 12'h167, 8'h14);
		ion(1);
		chk("comb state", op_state, 2);
		chk("comb fan", fan_speed_out, 7);
		chk("comb swing", swing_out, 2);
		chk("comb opts", {powerful_en, quiet_en}, 0);
		chk("slow fan gen", gen_power, 0);
		i_igc_remote.env(1, 1, 12'h168, 8'h14);
		cyc(4);
		chk("fast fan gen", gen_power, 1);
		@(posedge sys_clk);
		check_mode <= 1'h1;
		gen_abnormal <= 1'h1;
		for (int i = 0; i < 1400 && nv_fault_wr !== 1'h1; i++)
			cyc(1);
		chk("fault store", nv_fault_wr, 1);
		cyc(2);
		chk("fault blink", timer_led_blink, 1);
		chk("fault lamp", ion_led, 0);
		chk("backoff gen", gen_power, 0);
		rd(4'h8);
		chk("disc count", d[3:0], 1);
		ion(0);
		chk("power stop", op_state, 0);
		rd(4'h8);
		chk("check keep", d[3:0], 1);
		@(posedge sys_clk);
		check_mode <= 1'h0;
		gen_abnormal <= 1'h0;
		i_igc_remote.env(0, 1, 12'h190, 8'h14);
		ion(1);
		ion(1);
		wr(4'h8);
		rd(4'h8);
		chk("stop clear", d, 0);
		rd(4'hC);
		chk("unmapped", d, 0);
		// Mode controller keeps running across the outage, so combination holds
		i_igc_remote.env(1, 1, 12'h190, 8'h14);
		@(posedge sys_clk);
		nv_valid <= 1'h1;
		nv_op_state <= 2'h2;
		nrst <= 1'h0;
		cyc(8);
		nrst <= 1'h1;
		cyc(3);
		chk("resume state", op_state, 2);
		rd(4'h4);
		chk("stat state", d[1:0], 2);
		complete_run();
	end
endmodule
bind igc_top igc_top_asserts i_igc_top_asserts(.sys_clk, .nrst, .cmd_power, .cmd_ion_btn,
	.on_timer_fire, .off_timer_fire, .mode_running, .mode_ctrl_stop, .fan_running, .fan_rpm,
	.intake_temp, .remote_fan, .mode_swing, .reg_rd, .reg_rdata, .gen_power, .fan_speed_out,
	.swing_out, .powerful_en, .quiet_en, .ion_led, .nv_fault_wr, .op_state);
